// ---- core/jdp_top.sv ----
// Operation
// R1: Trace needs comm mode, enables, trigger edge
// R2: Trace read data written to external address
// R3: Trace address upper byte from JTAG register
// R4: Config bit 5 selects word/half trace read
// R5: Host should request top priority, supervisor
// R6: Unselected port saves power; status stays
// R7: Config register JTAG-only, resets to zero
// R8: Config bit 0 selects comm or RW
// R9: Config bit 1 clears write/half flags once
// R10: Config bit 2 sets high-level sync flag
// R11: Config bit 3 makes RW transfers wait trigger
// R12: Config bit 4 enables external bus trace
// R13: Config bit 6 sets bus priority
// R14: Config bit 7 selects supervisor transfers
// R15: Config bits 10:8 choose trigger source
// R16: Status bit 0 locks out RW mode
// R17: Status bit 1 user flag, JTAG reset only
// R18: Status bits 2-4 read-only sync flags
// R19: Status bits 7:5 mirror trigger source
// R20: Status bits 31:8 read zero
// R21: Comm data and status at fixed addresses
// R22: RW entry needs lockout clear and write
// R23: Reset starts in comm mode, no accesses
// R24: Config update acts once per JTAG update
// R25: Trace address is upper byte plus constant
`timescale 1ns/1ps
`default_nettype none
module jdp_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic jtag_tck,
  input wire logic jtag_tms,
  input wire logic jtag_tdi,
  input wire logic jtag_trst_n,
  output logic jtag_tdo,
  output logic jtag_tdo_oe,
  input wire logic trig_cpu,
  input wire logic trig_copro,
  input wire logic bus_sel,
  input wire logic bus_we,
  input wire logic bus_sv,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  output logic bus_ack,
  output logic bus_err,
  output logic [31:0] bus_rdata,
  output logic mst_req,
  output logic mst_we,
  output logic mst_half,
  output logic mst_prio,
  output logic mst_sv,
  output logic [31:0] mst_addr,
  output logic [31:0] mst_wdata,
  input wire logic [31:0] mst_rdata,
  input wire logic mst_ack,
  output logic power_save
);
  import jdp_pkg::*;

  typedef struct packed {
    jdp_tap_t tap;
    logic [IR_W-1:0] ir;
    logic [IR_W-1:0] ir_sh;
    logic [DR_W-1:0] sh;
    logic tdo;
    logic tdo_oe;
    logic mode;
    logic trig_en;
    logic ext_en;
    logic half;
    logic prio;
    logic sv;
    logic [2:0] chan;
    logic [TRACE_UPPER_ADDRESS_REG_W-1:0] trace_upper_address_reg;
    logic [31:0] addr;
    logic [31:0] adata;
    logic [31:0] comm;
    logic lock;
    logic user;
    logic rsync;
    logic wsync;
    logic hsync;
    logic csync;
    logic pend;
    logic pend_we;
    logic start;
    jdp_kind_t kind;
    logic ack;
    logic err;
    logic [31:0] rdata;
    logic psave;
  } jdp_top_st_t;

  jdp_top_st_t q;
  jdp_top_st_t d;
  logic [PIN_W-1:0] pin_q;
  logic [PIN_W-1:0] pin_rise;
  logic [PIN_W-1:0] pin_fall;
  jdp_mst_if m ();

  jdp_sync #(.W(PIN_W), .INIT(PIN_RESET)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({trig_copro, trig_cpu, jtag_tdi, jtag_tms, jtag_tck, jtag_trst_n}),
    .q(pin_q),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  jdp_master u_master (
    .clk(clk),
    .rst_n(rst_n),
    .m(m),
    .mst_req(mst_req),
    .mst_we(mst_we),
    .mst_half(mst_half),
    .mst_prio(mst_prio),
    .mst_sv(mst_sv),
    .mst_addr(mst_addr),
    .mst_wdata(mst_wdata),
    .mst_rdata(mst_rdata),
    .mst_ack(mst_ack)
  );

  function automatic jdp_tap_t tap_next(input jdp_tap_t s, input logic tms);
    case (s)
      T_RESET: tap_next = tms ? T_RESET : T_IDLE;
      T_IDLE: tap_next = tms ? T_SEL_DR : T_IDLE;
      T_SEL_DR: tap_next = tms ? T_SEL_IR : T_CAP_DR;
      T_CAP_DR: tap_next = tms ? T_EX1_DR : T_SH_DR;
      T_SH_DR: tap_next = tms ? T_EX1_DR : T_SH_DR;
      T_EX1_DR: tap_next = tms ? T_UPD_DR : T_PA_DR;
      T_PA_DR: tap_next = tms ? T_EX2_DR : T_PA_DR;
      T_EX2_DR: tap_next = tms ? T_UPD_DR : T_SH_DR;
      T_UPD_DR: tap_next = tms ? T_SEL_DR : T_IDLE;
      T_SEL_IR: tap_next = tms ? T_RESET : T_CAP_IR;
      T_CAP_IR: tap_next = tms ? T_EX1_IR : T_SH_IR;
      T_SH_IR: tap_next = tms ? T_EX1_IR : T_SH_IR;
      T_EX1_IR: tap_next = tms ? T_UPD_IR : T_PA_IR;
      T_PA_IR: tap_next = tms ? T_EX2_IR : T_PA_IR;
      T_EX2_IR: tap_next = tms ? T_UPD_IR : T_SH_IR;
      T_UPD_IR: tap_next = tms ? T_SEL_DR : T_IDLE;
      default: tap_next = T_RESET;
    endcase
  endfunction

  logic tck_rise;
  logic tck_fall;
  logic selected;
  logic upd;
  logic trg_edge;
  logic [CFG_W-1:0] cfg_in;
  logic cpu_comm_rd;
  logic cpu_comm_wr;
  logic [31:0] status_word;

  assign tck_rise = pin_rise[PIN_TCK];
  assign tck_fall = pin_fall[PIN_TCK];
  assign selected = (q.ir != IR_BYPASS); // R6
  assign upd = tck_rise && (q.tap == T_UPD_DR); // R24
  assign cfg_in = q.sh[DR_W-1:CFG_SH_LO];
  assign trg_edge = ((q.chan == CH_CPU) && pin_rise[PIN_TRIG_CPU]) ||
                    ((q.chan == CH_COPRO) && pin_rise[PIN_TRIG_COPRO]); // R15
  assign cpu_comm_rd = bus_sel && !bus_we && (bus_addr == COMM_DATA_ADDR) && selected;
  assign cpu_comm_wr = bus_sel && bus_we && (bus_addr == COMM_DATA_ADDR) && selected;
  assign status_word = {24'h000000, q.chan, q.csync, q.wsync, q.rsync, q.user,
                        q.lock}; // R18 R19 R20

  always_comb begin
    d = q;
    d.start = 1'b0;
    d.ack = 1'b0;
    d.err = 1'b0;
    d.rdata = 32'h0000_0000;
    d.psave = !selected; // R6

    if (tck_rise) begin
      d.tap = tap_next(q.tap, pin_q[PIN_TMS]);
      case (q.tap)
        T_RESET: d.ir = IR_BYPASS;
        T_CAP_IR: d.ir_sh = IR_CAPTURE;
        T_SH_IR: d.ir_sh = {pin_q[PIN_TDI], q.ir_sh[IR_W-1:1]};
        T_UPD_IR: d.ir = q.ir_sh;
        T_CAP_DR: begin
          case (q.ir)
            IR_ADDR: d.sh = q.addr;
            IR_RW_RD: d.sh = q.adata;
            IR_COMM_RD: d.sh = q.comm;
            default: d.sh = '0;
          endcase
        end
        T_SH_DR: d.sh = {pin_q[PIN_TDI], q.sh[DR_W-1:1]};
        default: ;
      endcase
    end
    if (tck_fall) begin
      // Bypass takes its single bit from the top of the shift chain
      if (q.tap == T_SH_IR) begin
        d.tdo = q.ir_sh[0];
      end else if (q.ir == IR_BYPASS) begin
        d.tdo = q.sh[DR_W-1];
      end else begin
        d.tdo = q.sh[0];
      end
      d.tdo_oe = (q.tap == T_SH_IR) || (q.tap == T_SH_DR);
    end

    // Flags: clears first, sets last so a set in the same cycle wins
    if (cpu_comm_rd) begin
      d.wsync = 1'b0;
      d.hsync = 1'b0;
    end
    if (cpu_comm_wr) begin
      d.csync = 1'b0;
    end

    if (upd) begin
      case (q.ir)
        IR_CONFIG: begin
          // Leaving RW mode is always allowed, entering only when unlocked
          d.mode = cfg_in[CFG_MODE] && (q.mode || !q.lock); // R8 R22 R16
          d.trig_en = cfg_in[CFG_TRIG_EN]; // R11
          d.ext_en = cfg_in[CFG_EXT_EN]; // R12
          d.half = cfg_in[CFG_HALF]; // R4
          d.prio = cfg_in[CFG_PRIO]; // R13
          d.sv = cfg_in[CFG_SV]; // R14
          d.chan = cfg_in[CFG_CH_HI:CFG_CH_LO]; // R15 R19
          if (cfg_in[CFG_FLAG_CLR]) begin
            d.wsync = 1'b0; // R9
            d.hsync = 1'b0; // R9
          end
          if (cfg_in[CFG_FLAG_SET]) begin
            d.csync = 1'b1; // R10
          end
        end
        IR_TRACE_UPPER_ADDRESS_REG: d.trace_upper_address_reg = q.sh[DR_W-1:TRACE_UPPER_ADDRESS_REG_SH_LO]; // R3
        IR_ADDR: d.addr = q.sh;
        IR_RW_RD: begin
          d.pend = q.mode;
          d.pend_we = 1'b0;
        end
        IR_RW_WR: begin
          d.adata = q.sh;
          d.pend = q.mode;
          d.pend_we = 1'b1;
        end
        IR_COMM_RD: d.rsync = 1'b0;
        IR_COMM_WR: begin
          d.comm = q.sh;
          d.wsync = 1'b1;
        end
        IR_COMM_WRH: begin
          d.comm = q.sh;
          d.wsync = 1'b1;
          d.hsync = 1'b1;
        end
        default: ;
      endcase
    end

    if (bus_sel) begin
      d.ack = 1'b1;
      if (bus_addr == STATUS_ADDR) begin // R21
        if (bus_we) begin
          if (bus_wdata[ST_LOCK] && bus_sv && !q.mode) begin
            d.lock = 1'b1; // R16
          end
          d.user = bus_wdata[ST_USER]; // R17
        end else begin
          d.rdata = status_word;
        end
      end else if (bus_addr == COMM_DATA_ADDR && selected) begin // R21 R6
        if (bus_we) begin
          d.comm = bus_wdata;
          d.rsync = 1'b1;
        end else begin
          d.rdata = q.comm;
        end
      end else begin
        d.err = 1'b1;
      end
    end

    if (!q.mode) begin
      d.pend = 1'b0; // R23
    end
    if (m.done && q.kind == K_READ) begin
      d.adata = m.rdata;
    end
    if (!m.busy && !q.start && selected) begin
      if (q.pend && q.mode && (!q.trig_en || trg_edge)) begin // R11
        d.start = 1'b1;
        d.kind = q.pend_we ? K_WRITE : K_READ;
        d.pend = 1'b0;
      end else if (!q.mode && q.trig_en && q.ext_en && trg_edge) begin // R1
        d.start = 1'b1;
        d.kind = K_TRACE; // R2
      end
    end

    if (!pin_q[PIN_TRST]) begin
      d.tap = T_RESET;
      d.ir = IR_BYPASS;
      d.user = 1'b0; // R17
    end
    if (!rst_n) begin
      d = '0;
      d.tap = T_RESET;
      d.ir = IR_BYPASS;
      d.kind = K_READ;
      d.mode = CFG_RESET[CFG_MODE]; // R7 R23
      d.trig_en = CFG_RESET[CFG_TRIG_EN];
      d.ext_en = CFG_RESET[CFG_EXT_EN];
      d.half = CFG_RESET[CFG_HALF];
      d.prio = CFG_RESET[CFG_PRIO];
      d.sv = CFG_RESET[CFG_SV];
      d.chan = CFG_RESET[CFG_CH_HI:CFG_CH_LO];
      d.psave = 1'b1;
      // User flag survives a bus reset; only the JTAG reset clears it
      d.user = pin_q[PIN_TRST] ? q.user : 1'b0; // R17
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign m.start = q.start;
  assign m.kind = q.kind;
  assign m.addr = q.addr;
  assign m.wdata = q.adata;
  assign m.trace_addr = {q.trace_upper_address_reg, TRACE_LOW_ADDR}; // R3 R25
  assign m.half = q.half;
  assign m.prio = q.prio;
  assign m.sv = q.sv;

  assign jtag_tdo = q.tdo;
  assign jtag_tdo_oe = q.tdo_oe;
  assign bus_ack = q.ack;
  assign bus_err = q.err;
  assign bus_rdata = q.rdata;
  assign power_save = q.psave;
endmodule
`default_nettype wire

// ---- core/jdp_pkg.sv ----
package jdp_pkg;
  localparam int IR_W = 4;
  localparam int DR_W = 32;
  localparam int CFG_W = 12;
  localparam int TRACE_UPPER_ADDRESS_REG_W = 8;
  localparam int CFG_SH_LO = DR_W - CFG_W;
  localparam int TRACE_UPPER_ADDRESS_REG_SH_LO = DR_W - TRACE_UPPER_ADDRESS_REG_W;

  localparam logic [31:0] COMM_DATA_ADDR = 32'hF000_0468;
  localparam logic [31:0] STATUS_ADDR = 32'hF000_046C;
  localparam logic [23:0] TRACE_LOW_ADDR = 24'h10F06A;
  localparam logic [11:0] CFG_RESET = 12'h000;

  localparam int CFG_MODE = 0;
  localparam int CFG_FLAG_CLR = 1;
  localparam int CFG_FLAG_SET = 2;
  localparam int CFG_TRIG_EN = 3;
  localparam int CFG_EXT_EN = 4;
  localparam int CFG_HALF = 5;
  localparam int CFG_PRIO = 6;
  localparam int CFG_SV = 7;
  localparam int CFG_CH_LO = 8;
  localparam int CFG_CH_HI = 10;

  localparam int ST_LOCK = 0;
  localparam int ST_USER = 1;
  localparam int ST_RSYNC = 2;
  localparam int ST_WSYNC = 3;
  localparam int ST_HSYNC = 4;
  localparam int ST_CH_LO = 5;
  localparam int ST_CH_HI = 7;

  localparam logic [2:0] CH_CPU = 3'h1;
  localparam logic [2:0] CH_COPRO = 3'h2;

  localparam logic [IR_W-1:0] IR_CONFIG = 4'h1;
  localparam logic [IR_W-1:0] IR_TRACE_UPPER_ADDRESS_REG = 4'h2;
  localparam logic [IR_W-1:0] IR_ADDR = 4'h3;
  localparam logic [IR_W-1:0] IR_RW_RD = 4'h4;
  localparam logic [IR_W-1:0] IR_RW_WR = 4'h5;
  localparam logic [IR_W-1:0] IR_COMM_RD = 4'h6;
  localparam logic [IR_W-1:0] IR_COMM_WR = 4'h7;
  localparam logic [IR_W-1:0] IR_COMM_WRH = 4'h8;
  localparam logic [IR_W-1:0] IR_BYPASS = 4'hF;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

  localparam int PIN_TRST = 0;
  localparam int PIN_TCK = 1;
  localparam int PIN_TMS = 2;
  localparam int PIN_TDI = 3;
  localparam int PIN_TRIG_CPU = 4;
  localparam int PIN_TRIG_COPRO = 5;
  localparam int PIN_W = 6;
  localparam logic [PIN_W-1:0] PIN_RESET = 6'h01;

  typedef enum logic [1:0] {K_READ, K_WRITE, K_TRACE} jdp_kind_t;
  typedef enum logic [1:0] {E_IDLE, E_XFER, E_TWR} jdp_eng_t;
  typedef enum logic [3:0] {
    T_RESET, T_IDLE, T_SEL_DR, T_CAP_DR, T_SH_DR, T_EX1_DR, T_PA_DR, T_EX2_DR,
    T_UPD_DR, T_SEL_IR, T_CAP_IR, T_SH_IR, T_EX1_IR, T_PA_IR, T_EX2_IR, T_UPD_IR
  } jdp_tap_t;
endpackage

// ---- core/jdp_mst_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface jdp_mst_if;
  import jdp_pkg::*;
  logic start;
  jdp_kind_t kind;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [31:0] trace_addr;
  logic half;
  logic prio;
  logic sv;
  logic busy;
  logic done;
  logic [31:0] rdata;
  modport ctl (output start, kind, addr, wdata, trace_addr, half, prio, sv,
               input busy, done, rdata);
  modport eng (input start, kind, addr, wdata, trace_addr, half, prio, sv,
               output busy, done, rdata);
endinterface
`default_nettype wire

// ---- core/jdp_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module jdp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  typedef struct packed {
    logic [W-1:0] m1;
    logic [W-1:0] m2;
    logic [W-1:0] p;
  } jdp_sync_st_t;

  jdp_sync_st_t s_q;
  jdp_sync_st_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.m1 = d;
    s_d.m2 = s_q.m1;
    s_d.p = s_q.m2;
    if (!rst_n) begin
      s_d = '{m1: INIT, m2: INIT, p: INIT};
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  // Edges are taken between the second and third stage only
  assign q = s_q.m2;
  assign rise = s_q.m2 & ~s_q.p;
  assign fall = ~s_q.m2 & s_q.p;
endmodule
`default_nettype wire

// ---- core/jdp_master.sv ----
`timescale 1ns/1ps
`default_nettype none
module jdp_master (
  input wire logic clk,
  input wire logic rst_n,
  jdp_mst_if.eng m,
  output logic mst_req,
  output logic mst_we,
  output logic mst_half,
  output logic mst_prio,
  output logic mst_sv,
  output logic [31:0] mst_addr,
  output logic [31:0] mst_wdata,
  input wire logic [31:0] mst_rdata,
  input wire logic mst_ack
);
  import jdp_pkg::*;

  typedef struct packed {
    jdp_eng_t st;
    jdp_kind_t kind;
    logic req;
    logic we;
    logic half;
    logic prio;
    logic sv;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] taddr;
    logic busy;
    logic done;
    logic [31:0] rdata;
  } jdp_eng_st_t;

  jdp_eng_st_t q;
  jdp_eng_st_t d;

  always_comb begin
    d = q;
    d.done = 1'b0;
    case (q.st)
      E_IDLE: begin
        if (m.start) begin
          d.kind = m.kind;
          d.req = 1'b1;
          d.busy = 1'b1;
          d.we = (m.kind == K_WRITE);
          d.half = (m.kind == K_TRACE) && m.half; // R4
          d.prio = m.prio; // R13
          d.sv = m.sv; // R14
          d.addr = m.addr;
          d.wdata = m.wdata;
          d.taddr = m.trace_addr;
          d.st = E_XFER;
        end
      end
      E_XFER: begin
        if (mst_ack) begin
          if (q.kind == K_TRACE) begin
            // Read data goes straight back out to the trace box address
            d.we = 1'b1; // R2
            d.addr = q.taddr; // R2
            d.wdata = mst_rdata;
            d.st = E_TWR;
          end else begin
            d.req = 1'b0;
            d.busy = 1'b0;
            d.done = 1'b1;
            d.rdata = mst_rdata;
            d.st = E_IDLE;
          end
        end
      end
      E_TWR: begin
        if (mst_ack) begin
          d.req = 1'b0;
          d.busy = 1'b0;
          d.done = 1'b1;
          d.st = E_IDLE;
        end
      end
      default: d.st = E_IDLE;
    endcase
    if (!rst_n) begin
      d = '0;
      d.st = E_IDLE;
      d.kind = K_READ;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign mst_req = q.req;
  assign mst_we = q.we;
  assign mst_half = q.half;
  assign mst_prio = q.prio;
  assign mst_sv = q.sv;
  assign mst_addr = q.addr;
  assign mst_wdata = q.wdata;
  assign m.busy = q.busy;
  assign m.done = q.done;
  assign m.rdata = q.rdata;
endmodule
`default_nettype wire

// ---- tb/jdp_top_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module jdp_top_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bus_sel,
  input wire logic bus_we,
  input wire logic [31:0] bus_addr,
  input wire logic bus_ack,
  input wire logic bus_err,
  input wire logic [31:0] bus_rdata,
  input wire logic mst_req,
  input wire logic mst_we,
  input wire logic mst_half,
  input wire logic mst_prio,
  input wire logic mst_sv,
  input wire logic [31:0] mst_addr,
  input wire logic [31:0] mst_wdata,
  input wire logic [31:0] mst_rdata,
  input wire logic mst_ack,
  input wire logic power_save
);
  import jdp_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  bus_answer_a: assert property (1'b1 |=> bus_ack == $past(bus_sel))
    else $error("bus ack not one cycle after select");
  unmapped_err_a: assert property (bus_sel && bus_addr != COMM_DATA_ADDR
    && bus_addr != STATUS_ADDR |=> bus_ack && bus_err)
    else $error("unmapped access not refused");
  status_read_a: assert property (bus_sel && !bus_we && bus_addr == STATUS_ADDR
    |=> !bus_err && bus_rdata[31:8] == 24'h0)
    else $error("status read bad upper bits or error");
  saved_comm_a: assert property (bus_sel && power_save
    && bus_addr == COMM_DATA_ADDR |=> bus_err)
    else $error("comm data reachable while unselected");
  idle_start_a: assert property ($rose(mst_req) |-> !power_save)
    else $error("master request while unselected");
  reset_state_a: assert property ($rose(rst_n) |-> !mst_req && power_save)
    else $error("wrong state after reset");
  req_hold_a: assert property (mst_req && !mst_ack |=> mst_req
    && $stable({mst_we, mst_half, mst_prio, mst_sv, mst_addr, mst_wdata}))
    else $error("master request changed before ack");
  trace_write_a: assert property (mst_req && $past(mst_ack && !mst_we)
    |-> mst_we && mst_addr[23:0] == TRACE_LOW_ADDR && mst_wdata == $past(mst_rdata))
    else $error("trace write address or data wrong");
  trace_size_a: assert property (mst_req && $past(mst_ack && !mst_we)
    |-> mst_half == $past(mst_half))
    else $error("trace write size differs from read");
  write_end_a: assert property (mst_ack && mst_we |=> !mst_req)
    else $error("request held after write ack");
endmodule
bind jdp_top jdp_top_properties u_props (.clk, .rst_n, .bus_sel, .bus_we, .bus_addr,
  .bus_ack, .bus_err, .bus_rdata, .mst_req, .mst_we, .mst_half, .mst_prio, .mst_sv,
  .mst_addr, .mst_wdata, .mst_rdata, .mst_ack, .power_save);
`default_nettype wire

// ---- tb/jdp_bus_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module jdp_bus_model #(
  parameter logic [31:0] KEY = 32'h5A5AC3C3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mst_req,
  input wire logic [31:0] mst_addr,
  input wire logic [3:0] delay,
  output logic mst_ack,
  output logic [31:0] mst_rdata
);
  logic [3:0] wait_q;
  // Read data toggles outside the ack cycle so a stale capture cannot pass
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wait_q <= 4'h0;
      mst_ack <= 1'b0;
      mst_rdata <= 32'h0;
    end else if (mst_req && !mst_ack && wait_q >= delay) begin
      mst_ack <= 1'b1;
      mst_rdata <= mst_addr ^ KEY;
    end else begin
      wait_q <= (mst_req && !mst_ack) ? wait_q + 4'h1 : 4'h0;
      mst_ack <= 1'b0;
      mst_rdata <= ~mst_rdata;
    end
  end
endmodule
`default_nettype wire

// ---- tb/jdp_top_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module jdp_top_test;
  import jdp_pkg::*;
  localparam logic [31:0] KEY = 32'h5A5AC3C3;
  localparam logic [11:0] CFG [6] = '{12'h1DC, 12'h2FC, 12'h1DC, 12'h1D4, 12'h1CC, 12'h1DD};
  localparam logic [5:0] COPRO = 6'b000110;
  localparam logic [5:0] GO = 6'b100011;
  logic clk, rst_n, jtag_tck, jtag_tms, jtag_tdi, jtag_trst_n, jtag_tdo, jtag_tdo_oe;
  logic trig_cpu, trig_copro, bus_sel, bus_we, bus_sv, bus_ack, bus_err, power_save;
  logic mst_req, mst_we, mst_half, mst_prio, mst_sv, mst_ack;
  logic [31:0] bus_addr, bus_wdata, bus_rdata, mst_addr, mst_wdata, mst_rdata;
  logic [31:0] seed, acc_addr;
  logic [3:0] delay;
  logic [7:0] tr_addr;
  logic [11:0] c;
  logic [31:0] sh_out;
  logic [1:0] tdo_s;
  logic oe_ok;
  logic [32:0] be;
  logic [65:0] me;
  logic [32:0] bus_q[$];
  logic [65:0] mst_q[$];
  int mismatches, checks;

  jdp_top dut (.clk, .rst_n, .jtag_tck, .jtag_tms, .jtag_tdi, .jtag_trst_n, .jtag_tdo,
    .jtag_tdo_oe, .trig_cpu, .trig_copro, .bus_sel, .bus_we, .bus_sv, .bus_addr, .bus_wdata,
    .bus_ack, .bus_err, .bus_rdata, .mst_req, .mst_we, .mst_half, .mst_prio, .mst_sv,
    .mst_addr, .mst_wdata, .mst_rdata, .mst_ack, .power_save);
  jdp_bus_model #(.KEY(KEY)) far (.clk, .rst_n, .mst_req, .mst_addr, .delay, .mst_ack,
    .mst_rdata);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic note(input string what, input logic [65:0] exp, input logic [65:0] got);
    checks++;
    if (exp !== got) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tbit(input logic ms, input logic di);
    {jtag_tck, jtag_tms, jtag_tdi} <= {1'b0, ms, di};
    repeat (6) @(posedge clk);
    // Output bit was launched at the synced fall, well before this point
    tdo_s = {jtag_tdo_oe, jtag_tdo};
    jtag_tck <= 1'b1;
    repeat (6) @(posedge clk);
  endtask

  // Starts and ends in Run-Test/Idle
  task automatic scan(input logic ir, input logic [31:0] v, input int n);
    oe_ok = 1'b1;
    tbit(1'b1, 1'b0);
    if (ir) tbit(1'b1, 1'b0);
    tbit(1'b0, 1'b0);
    tbit(1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      tbit(i == n - 1, v[i]);
      sh_out[i] = tdo_s[0];
      oe_ok &= tdo_s[1];
    end
    tbit(1'b1, 1'b0);
    tbit(1'b0, 1'b0);
  endtask

  task automatic bus(input logic we, input logic sv, input logic [31:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    bus_q.push_back(e);
    {bus_sel, bus_we, bus_sv, bus_addr, bus_wdata} <= {1'b1, we, sv, a, d};
    @(posedge clk);
    bus_sel <= 1'b0;
    @(posedge clk);
  endtask

  // Trigger edges during a transfer are lost, so wait for the queue to drain
  task automatic fire(input logic copro);
    {trig_cpu, trig_copro} <= {~copro, copro};
    repeat (4) @(posedge clk);
    {trig_cpu, trig_copro} <= 2'b00;
    for (int i = 0; i < 300 && mst_q.size() > 0; i++) @(posedge clk);
    repeat (40) @(posedge clk);
    note("pending transfers", 66'h0, 66'(mst_q.size()));
    mst_q.delete();
  endtask

  always @(posedge clk) begin
    if (bus_ack === 1'b1) begin
      be = (bus_q.size() > 0) ? bus_q.pop_front() : 33'h0;
      note("bus answer", {33'h0, be}, {33'h0, bus_err, be[32] ? be[31:0] : bus_rdata});
    end
    if (mst_req === 1'b1 && mst_ack === 1'b1) begin
      me = (mst_q.size() > 0) ? mst_q.pop_front() : '1;
      note("bus master", me, {mst_half, mst_we, mst_addr, mst_we ? mst_wdata : 32'h0});
      note("master prio sv", {64'h0, c[6], c[7]}, {64'h0, mst_prio, mst_sv});
    end
  end

  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    close_out();
  end

  initial begin
    {rst_n, jtag_trst_n, jtag_tck, jtag_tms, jtag_tdi, trig_cpu, trig_copro} = 7'h00;
    {bus_sel, bus_we, bus_sv, bus_addr, bus_wdata, delay} = '0;
    seed = 32'hfb508e07;
    repeat (10) @(posedge clk);
    // The pin synchroniser is held in bus reset, so the JTAG reset must outlast it
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    jtag_trst_n <= 1'b1;
    repeat (3) @(posedge clk);
    tbit(1'b0, 1'b0);
    @(negedge clk);
    note("power save", 66'h1, {65'h0, power_save});
    bus(1'b0, 1'b0, STATUS_ADDR, 32'h0, 33'h0);
    bus(1'b0, 1'b0, COMM_DATA_ADDR, 32'h0, {1'b1, 32'h0});
    bus(1'b1, 1'b1, rnd() & 32'h0FFFFFFC, 32'h0, {1'b1, 32'h0});
    bus(1'b1, 1'b0, STATUS_ADDR, 32'h1, 33'h0);
    bus(1'b0, 1'b0, STATUS_ADDR, 32'h0, 33'h0);
    tr_addr = 8'(rnd());
    acc_addr = rnd();
    scan(1'b1, 32'(IR_TRACE_UPPER_ADDRESS_REG), 4);
    scan(1'b0, 32'(tr_addr), 8);
    scan(1'b1, 32'(IR_ADDR), 4);
    scan(1'b0, acc_addr, 32);
    @(negedge clk);
    note("power save", 66'h0, {65'h0, power_save});
    c = 12'h1C9;
    scan(1'b1, 32'(IR_CONFIG), 4);
    scan(1'b0, {20'h0, c}, 12);
    scan(1'b1, 32'(IR_RW_RD), 4);
    scan(1'b0, 32'h0, 1);
    mst_q.push_back({1'b0, 1'b0, acc_addr, 32'h0});
    fire(1'b0);
    scan(1'b0, 32'h0, 32);
    note("tdo readback", {33'h0, 1'b1, acc_addr ^ KEY}, {33'h0, oe_ok, sh_out});
    for (int i = 0; i < 6; i++) begin
      c = CFG[i];
      if (i == 5) bus(1'b1, 1'b1, STATUS_ADDR, 32'h1, 33'h0);
      scan(1'b1, 32'(IR_CONFIG), 4);
      scan(1'b0, {20'h0, c}, 12);
      bus(1'b0, 1'b0, STATUS_ADDR, 32'h0, {25'h0, c[10:8], 4'h8, i == 5});
      delay <= 4'(rnd() & 32'h7);
      if (GO[i]) begin
        mst_q.push_back({c[5], 1'b0, acc_addr, 32'h0});
        mst_q.push_back({c[5], 1'b1, tr_addr, TRACE_LOW_ADDR, acc_addr ^ KEY});
      end
      fire(COPRO[i]);
    end
    bus(1'b1, 1'b1, STATUS_ADDR, 32'hFFFFFFFE, 33'h0);
    bus(1'b0, 1'b0, STATUS_ADDR, 32'h0, 33'h33);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    note("power save", 66'h1, {65'h0, power_save});
    bus(1'b0, 1'b0, STATUS_ADDR, 32'h0, 33'h2);
    fire(1'b0);
    close_out();
  end
endmodule
`default_nettype wire
